/* rtl/clock_mode_ratio_decoder.sv */
/*
  top of the clock ratio decoder: samples the straps during reset and holds ratios.
  assumes straps are synchronous to ref_clk and steady around reset release.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - host codes 0101_000..100: comm 2, core 2.5..4.5, pci div 2 or 4.
// - host codes 0110_000..100: comm 2.5, core 2.5..4.5, pci div 3 or 6.
// - host codes 0111_000..100: comm 3, core 2.5..4.5, pci div 3 or 6.
// - host codes 1000_000..100: comm 3, core 2.5..4.5, pci div 4 or 8.
// - host codes 1001_000..100: comm 3.5, core 2.5..4.5, pci div 4 or 8.
// - host codes 1010_000..100: comm 2, core 2..4, pci div 3 or 6.
// - host codes 1011_000..100: comm 2.5, core 2..4, pci div 4 or 8.
// - host codes 0011_010/011: comm 5, core 7 or 8, pci div 5.
// - halving strap high doubles the host pci divider, except on the low-reference codes 0011_010/011 and 0100_000..011.
// - general codes 0011_100..0100_000: comm 6, core 4..8.
// - general codes 0100_001..0101_100 are reserved, no valid ratio.
// - general codes 0101_101..0110_010: comm 2, core 2..4.5.
// - general codes 0110_011..0111_000: comm 2.5, core 2..4.5.
module clock_mode_ratio_decoder (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [clk_ratio_pkg::HIGH_W-1:0] clock_cfg_high,
  input wire logic [clk_ratio_pkg::LOW_W-1:0] clock_cfg_low,
  input wire logic pci_halving_strap,
  input wire logic pci_host_mode,
  output logic [clk_ratio_pkg::RATIO_W-1:0] comm_engine_mult_r,
  output logic [clk_ratio_pkg::RATIO_W-1:0] core_mult_r,
  output logic [clk_ratio_pkg::DIV_W-1:0] pci_div_r,
  output logic ratio_valid_r,
  output logic ratio_ready_r
);
  typedef enum logic [1:0] {SAMPLING, SETTLE, HOLD} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [clk_ratio_pkg::CODE_W-1:0] code;
    logic host;
    logic halve;
    logic [clk_ratio_pkg::RATIO_W-1:0] comm;
    logic [clk_ratio_pkg::RATIO_W-1:0] core;
    logic [clk_ratio_pkg::DIV_W-1:0] div;
    logic valid;
    logic ready;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;
  ratio_cfg_if cfg ();

  assign cfg.code = st_r.code;
  assign cfg.host_mode = st_r.host;
  assign cfg.halve = st_r.halve;

  ratio_table u_table (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cfg(cfg)
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r.phase)
      SAMPLING: begin
        // first cycle after release: straps were caught during reset, now look up
        st_nxt.phase = SETTLE;
      end
      SETTLE: begin
        st_nxt.phase = HOLD;
        st_nxt.comm = cfg.comm_mult;
        st_nxt.core = cfg.core_mult;
        st_nxt.div = cfg.pci_div;
        st_nxt.valid = cfg.valid;
        st_nxt.ready = 1'b1;
      end
      HOLD: st_nxt.phase = HOLD;
      default: st_nxt.phase = SAMPLING;
    endcase
  end

  // straps are caught by the clock while reset is held, never by the reset itself
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r.phase <= SAMPLING;
      st_r.code <= {clock_cfg_high, clock_cfg_low};
      st_r.host <= pci_host_mode;
      st_r.halve <= pci_halving_strap;
      st_r.comm <= '0;
      st_r.core <= '0;
      st_r.div <= '0;
      st_r.valid <= 1'b0;
      st_r.ready <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign comm_engine_mult_r = st_r.comm;
  assign core_mult_r = st_r.core;
  assign pci_div_r = st_r.div;
  assign ratio_valid_r = st_r.valid;
  assign ratio_ready_r = st_r.ready;

  sequence ready_rise_s;
    !st_r.ready ##1 st_r.ready;
  endsequence

  hold_stable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r.ready && clk_en |=> $stable(core_mult_r) && $stable(pci_div_r) && ratio_ready_r
      && $stable(comm_engine_mult_r) && $stable(ratio_valid_r))
    else $error("ratios changed after capture");

  ready_timing_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(sys_rst) && clk_en ##1 clk_en |=> ratio_ready_r)
    else $error("ratios not ready two cycles after reset release");

  invalid_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ready_rise_s ##0 !ratio_valid_r |-> core_mult_r == '0 && comm_engine_mult_r == '0
      && pci_div_r == '0)
    else $error("invalid code produced a ratio");

  reserved_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && !st_r.host && st_r.code > clk_ratio_pkg::GEN_6_LAST
      && st_r.code < clk_ratio_pkg::GEN_2_FIRST |-> !ratio_valid_r)
    else $error("reserved general code marked valid");

  host_halve_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && ratio_valid_r && st_r.host && st_r.halve
      && st_r.code[clk_ratio_pkg::CODE_W-1:clk_ratio_pkg::LOW_W] == clk_ratio_pkg::H_5
      |-> pci_div_r == clk_ratio_pkg::DIV_4)
    else $error("halving strap did not double divider");

  host_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && st_r.host && !st_r.halve && st_r.code == {clk_ratio_pkg::H_5, 3'h0}
      |-> ratio_valid_r && comm_engine_mult_r == clk_ratio_pkg::HALF_2
      && core_mult_r == clk_ratio_pkg::HALF_2P5 && pci_div_r == clk_ratio_pkg::DIV_2)
    else $error("host code 0101_000 decoded wrong");

  lowref_five_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && st_r.host && st_r.code == clk_ratio_pkg::LOWREF_5_LAST
      |-> core_mult_r == clk_ratio_pkg::HALF_8 && pci_div_r == clk_ratio_pkg::DIV_5)
    else $error("low reference code decoded wrong");

  general_six_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && !st_r.host && st_r.code == clk_ratio_pkg::GEN_6_LAST
      |-> ratio_valid_r && core_mult_r == clk_ratio_pkg::HALF_8 && pci_div_r == '0)
    else $error("general code 0100_000 decoded wrong");

  lowref_six_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && st_r.host && st_r.code == clk_ratio_pkg::LOWREF_6_FIRST
      |-> ratio_valid_r && comm_engine_mult_r == clk_ratio_pkg::HALF_6
      && core_mult_r == clk_ratio_pkg::HALF_5 && pci_div_r == clk_ratio_pkg::DIV_6)
    else $error("low reference code 0100_000 decoded wrong");

  host_plain_div_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && ratio_valid_r && st_r.host && !st_r.halve
      && st_r.code[clk_ratio_pkg::CODE_W-1:clk_ratio_pkg::LOW_W] == clk_ratio_pkg::H_8
      |-> comm_engine_mult_r == clk_ratio_pkg::HALF_3 && pci_div_r == clk_ratio_pkg::DIV_4)
    else $error("host code 1000 decoded wrong");

  general_two_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ratio_ready_r && !st_r.host && st_r.code == clk_ratio_pkg::GEN_2_FIRST
      |-> ratio_valid_r && comm_engine_mult_r == clk_ratio_pkg::HALF_2
      && core_mult_r == clk_ratio_pkg::HALF_2 && pci_div_r == '0)
    else $error("general code 0101_101 decoded wrong");
endmodule : clock_mode_ratio_decoder
`default_nettype wire

/* rtl/clk_ratio_pkg.sv */
/*
  constants for the clock ratio decoder: code fields, ratio encodings, mode selects.
  assumes ratios are carried in half-units (value x2) so 2.5 becomes 5.
*/
`default_nettype none
package clk_ratio_pkg;
  localparam int CODE_W = 7;
  localparam int LOW_W = 3;
  localparam int HIGH_W = 4;
  localparam int RATIO_W = 5;
  localparam int DIV_W = 4;
  // ratios in half steps
  localparam logic [RATIO_W-1:0] HALF_2 = 5'h04;
  localparam logic [RATIO_W-1:0] HALF_2P5 = 5'h05;
  localparam logic [RATIO_W-1:0] HALF_3 = 5'h06;
  localparam logic [RATIO_W-1:0] HALF_3P5 = 5'h07;
  localparam logic [RATIO_W-1:0] HALF_4 = 5'h08;
  localparam logic [RATIO_W-1:0] HALF_5 = 5'h0a;
  localparam logic [RATIO_W-1:0] HALF_6 = 5'h0c;
  localparam logic [RATIO_W-1:0] HALF_7 = 5'h0e;
  localparam logic [RATIO_W-1:0] HALF_8 = 5'h10;
  localparam logic [DIV_W-1:0] DIV_2 = 4'h2;
  localparam logic [DIV_W-1:0] DIV_3 = 4'h3;
  localparam logic [DIV_W-1:0] DIV_4 = 4'h4;
  localparam logic [DIV_W-1:0] DIV_5 = 4'h5;
  localparam logic [DIV_W-1:0] DIV_6 = 4'h6;
  localparam logic [LOW_W-1:0] LOW_LAST = 3'h4;
  localparam logic [HIGH_W-1:0] H_3 = 4'h3;
  localparam logic [HIGH_W-1:0] H_4 = 4'h4;
  localparam logic [HIGH_W-1:0] H_5 = 4'h5;
  localparam logic [HIGH_W-1:0] H_6 = 4'h6;
  localparam logic [HIGH_W-1:0] H_7 = 4'h7;
  localparam logic [HIGH_W-1:0] H_8 = 4'h8;
  localparam logic [HIGH_W-1:0] H_9 = 4'h9;
  localparam logic [HIGH_W-1:0] H_A = 4'ha;
  localparam logic [HIGH_W-1:0] H_B = 4'hb;
  localparam logic [CODE_W-1:0] GEN_6_FIRST = 7'h1c;
  localparam logic [CODE_W-1:0] GEN_6_LAST = 7'h20;
  localparam logic [CODE_W-1:0] GEN_2_FIRST = 7'h2d;
  localparam logic [CODE_W-1:0] GEN_2_LAST = 7'h32;
  localparam logic [CODE_W-1:0] GEN_25_FIRST = 7'h33;
  localparam logic [CODE_W-1:0] GEN_25_LAST = 7'h38;
  localparam logic [CODE_W-1:0] LOWREF_5_FIRST = 7'h1a;
  localparam logic [CODE_W-1:0] LOWREF_5_LAST = 7'h1b;
  localparam logic [CODE_W-1:0] LOWREF_6_FIRST = 7'h20;
  localparam logic [CODE_W-1:0] LOWREF_6_LAST = 7'h23;
endpackage : clk_ratio_pkg
`default_nettype wire

/* rtl/ratio_cfg_if.sv */
/*
  carrier between the top and the decode table: code in, ratios out.
  assumes both ends share ref_clk; the table is registered.
*/
`timescale 1ns/1ps
`default_nettype none
interface ratio_cfg_if;
  logic [clk_ratio_pkg::CODE_W-1:0] code;
  logic host_mode;
  logic halve;
  logic [clk_ratio_pkg::RATIO_W-1:0] comm_mult;
  logic [clk_ratio_pkg::RATIO_W-1:0] core_mult;
  logic [clk_ratio_pkg::DIV_W-1:0] pci_div;
  logic valid;
  modport top (output code, output host_mode, output halve,
    input comm_mult, input core_mult, input pci_div, input valid);
  modport table_end (input code, input host_mode, input halve,
    output comm_mult, output core_mult, output pci_div, output valid);
endinterface : ratio_cfg_if
`default_nettype wire

/* rtl/ratio_table.sv */
/*
  registered lookup of clock ratios from the seven-bit configuration code.
  assumes code and mode are steady while they are looked up; output lags one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ratio_table (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  ratio_cfg_if.table_end cfg
);
  typedef struct packed {
    logic [clk_ratio_pkg::RATIO_W-1:0] comm;
    logic [clk_ratio_pkg::RATIO_W-1:0] core;
    logic [clk_ratio_pkg::DIV_W-1:0] div;
    logic valid;
  } table_state_t;

  table_state_t st_r;
  table_state_t st_nxt;
  logic [clk_ratio_pkg::HIGH_W-1:0] hi;
  logic [clk_ratio_pkg::LOW_W-1:0] lo;

  // core ratio climbing in half steps from a base
  function automatic logic [clk_ratio_pkg::RATIO_W-1:0] step_up(
    input logic [clk_ratio_pkg::RATIO_W-1:0] base, input logic [clk_ratio_pkg::CODE_W-1:0] idx);
    step_up = base + idx[clk_ratio_pkg::RATIO_W-1:0];
  endfunction : step_up

  // whole-number core ratio stepping by one
  function automatic logic [clk_ratio_pkg::RATIO_W-1:0] step_whole(
    input logic [clk_ratio_pkg::RATIO_W-1:0] base, input logic [clk_ratio_pkg::CODE_W-1:0] idx);
    step_whole = base + {idx[clk_ratio_pkg::RATIO_W-2:0], 1'b0};
  endfunction : step_whole

  assign hi = cfg.code[clk_ratio_pkg::CODE_W-1:clk_ratio_pkg::LOW_W];
  assign lo = cfg.code[clk_ratio_pkg::LOW_W-1:0];

  always_comb begin
    st_nxt = '0;
    if (cfg.host_mode) begin
      if (lo <= clk_ratio_pkg::LOW_LAST) begin
        st_nxt.valid = 1'b1;
        case (hi)
          clk_ratio_pkg::H_5: begin
            st_nxt.comm = clk_ratio_pkg::HALF_2;
            st_nxt.core = step_up(clk_ratio_pkg::HALF_2P5, {4'h0, lo});
            st_nxt.div = clk_ratio_pkg::DIV_2;
          end
          clk_ratio_pkg::H_6: begin
            st_nxt.comm = clk_ratio_pkg::HALF_2P5;
            st_nxt.core = step_up(clk_ratio_pkg::HALF_2P5, {4'h0, lo});
            st_nxt.div = clk_ratio_pkg::DIV_3;
          end
          clk_ratio_pkg::H_7: begin
            st_nxt.comm = clk_ratio_pkg::HALF_3;
            st_nxt.core = step_up(clk_ratio_pkg::HALF_2P5, {4'h0, lo});
            st_nxt.div = clk_ratio_pkg::DIV_3;
          end
          clk_ratio_pkg::H_8: begin
            st_nxt.comm = clk_ratio_pkg::HALF_3;
            st_nxt.core = step_up(clk_ratio_pkg::HALF_2P5, {4'h0, lo});
            st_nxt.div = clk_ratio_pkg::DIV_4;
          end
          clk_ratio_pkg::H_9: begin
            st_nxt.comm = clk_ratio_pkg::HALF_3P5;
            st_nxt.core = step_up(clk_ratio_pkg::HALF_2P5, {4'h0, lo});
            st_nxt.div = clk_ratio_pkg::DIV_4;
          end
          clk_ratio_pkg::H_A: begin
            st_nxt.comm = clk_ratio_pkg::HALF_2;
            st_nxt.core = step_up(clk_ratio_pkg::HALF_2, {4'h0, lo});
            st_nxt.div = clk_ratio_pkg::DIV_3;
          end
          clk_ratio_pkg::H_B: begin
            st_nxt.comm = clk_ratio_pkg::HALF_2P5;
            st_nxt.core = step_up(clk_ratio_pkg::HALF_2, {4'h0, lo});
            st_nxt.div = clk_ratio_pkg::DIV_4;
          end
          default: st_nxt.valid = 1'b0;
        endcase
      end
      if (cfg.code >= clk_ratio_pkg::LOWREF_5_FIRST && cfg.code <= clk_ratio_pkg::LOWREF_5_LAST) begin
        st_nxt.valid = 1'b1;
        st_nxt.comm = clk_ratio_pkg::HALF_5;
        st_nxt.core = step_whole(clk_ratio_pkg::HALF_7, cfg.code - clk_ratio_pkg::LOWREF_5_FIRST);
        st_nxt.div = clk_ratio_pkg::DIV_5;
      end
      if (cfg.code >= clk_ratio_pkg::LOWREF_6_FIRST && cfg.code <= clk_ratio_pkg::LOWREF_6_LAST) begin
        st_nxt.valid = 1'b1;
        st_nxt.comm = clk_ratio_pkg::HALF_6;
        st_nxt.core = step_whole(clk_ratio_pkg::HALF_5, cfg.code - clk_ratio_pkg::LOWREF_6_FIRST);
        st_nxt.div = clk_ratio_pkg::DIV_6;
      end
      // the low-reference codes have a fixed divider; a raised strap there is
      // the board's fault and the divider stays as is
      if (cfg.halve && st_nxt.comm != clk_ratio_pkg::HALF_5
          && st_nxt.comm != clk_ratio_pkg::HALF_6) begin
        st_nxt.div = {st_nxt.div[clk_ratio_pkg::DIV_W-2:0], 1'b0};
      end
    end else begin
      // general set: no PCI divider, everything outside the listed spans is invalid
      if (cfg.code >= clk_ratio_pkg::GEN_6_FIRST && cfg.code <= clk_ratio_pkg::GEN_6_LAST) begin
        st_nxt.valid = 1'b1;
        st_nxt.comm = clk_ratio_pkg::HALF_6;
        st_nxt.core = step_whole(clk_ratio_pkg::HALF_4, cfg.code - clk_ratio_pkg::GEN_6_FIRST);
      end else if (cfg.code >= clk_ratio_pkg::GEN_2_FIRST
                   && cfg.code <= clk_ratio_pkg::GEN_2_LAST) begin
        st_nxt.valid = 1'b1;
        st_nxt.comm = clk_ratio_pkg::HALF_2;
        st_nxt.core = step_up(clk_ratio_pkg::HALF_2, cfg.code - clk_ratio_pkg::GEN_2_FIRST);
      end else if (cfg.code >= clk_ratio_pkg::GEN_25_FIRST
                   && cfg.code <= clk_ratio_pkg::GEN_25_LAST) begin
        st_nxt.valid = 1'b1;
        st_nxt.comm = clk_ratio_pkg::HALF_2P5;
        st_nxt.core = step_up(clk_ratio_pkg::HALF_2, cfg.code - clk_ratio_pkg::GEN_25_FIRST);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign cfg.comm_mult = st_r.comm;
  assign cfg.core_mult = st_r.core;
  assign cfg.pci_div = st_r.div;
  assign cfg.valid = st_r.valid;
endmodule : ratio_table
`default_nettype wire

/* verification/strap_model.sv */
/*
  board strapping model: presents the configuration code and straps while reset is high.
  assumes the bench sets the wanted values before reset and the decoder samples on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [clk_ratio_pkg::CODE_W-1:0] want_code,
  input wire logic want_halve,
  input wire logic want_host,
  output logic [clk_ratio_pkg::HIGH_W-1:0] clock_cfg_high,
  output logic [clk_ratio_pkg::LOW_W-1:0] clock_cfg_low,
  output logic pci_halving_strap,
  output logic pci_host_mode
);
  logic low_ref;
  assign low_ref = want_host && (want_code == 7'h1a || want_code == 7'h1b ||
    want_code[6:2] == 5'h08);
  initial begin
    {clock_cfg_high, clock_cfg_low} = 7'h00;
    pci_halving_strap = 1'b0;
    pci_host_mode = 1'b0;
  end
  // codes are swept blindly; keeping every clock within the part's rating is the board's
  // call, and the decoder must not care
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      {clock_cfg_high, clock_cfg_low} <= want_code;
      pci_halving_strap <= want_halve && !low_ref;
      pci_host_mode <= want_host;
    end else begin
      // released straps toggle every cycle so a late sample cannot hide
      {clock_cfg_high, clock_cfg_low} <= ~{clock_cfg_high, clock_cfg_low};
      pci_halving_strap <= ~pci_halving_strap;
      pci_host_mode <= ~pci_host_mode;
    end
  end
endmodule : strap_model
`default_nettype wire

/* verification/clock_mode_ratio_decoder_bench.sv */
/*
  self-checking bench for the clock ratio decoder: every code in both tables, stalls, holds.
  assumes the decoder answers on the second enabled edge after reset release.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_mode_ratio_decoder_bench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [clk_ratio_pkg::CODE_W-1:0] want_code = 7'h00;
  logic want_halve = 1'b0;
  logic want_host = 1'b0;
  logic [clk_ratio_pkg::HIGH_W-1:0] cfg_high;
  logic [clk_ratio_pkg::LOW_W-1:0] cfg_low;
  logic halving;
  logic host_mode;
  logic [clk_ratio_pkg::RATIO_W-1:0] comm_mult;
  logic [clk_ratio_pkg::RATIO_W-1:0] core_mult;
  logic [clk_ratio_pkg::DIV_W-1:0] pci_div;
  logic valid;
  logic ready;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [4:0] host_comm [7] = '{5'h04, 5'h05, 5'h06, 5'h06, 5'h07, 5'h04, 5'h05};
  logic [3:0] host_div [7] = '{4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h3, 4'h4};

  always #12.5 ref_clk = ~ref_clk;

  strap_model u_strap_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .want_code(want_code),
    .want_halve(want_halve), .want_host(want_host), .clock_cfg_high(cfg_high),
    .clock_cfg_low(cfg_low), .pci_halving_strap(halving), .pci_host_mode(host_mode));

  clock_mode_ratio_decoder u_clock_mode_ratio_decoder (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .clock_cfg_high(cfg_high), .clock_cfg_low(cfg_low),
    .pci_halving_strap(halving), .pci_host_mode(host_mode), .comm_engine_mult_r(comm_mult),
    .core_mult_r(core_mult), .pci_div_r(pci_div), .ratio_valid_r(valid), .ratio_ready_r(ready));

  // result packed as {valid, comm, core, div}, ratios in half units
  function automatic logic [14:0] expect_of(input logic [6:0] c, input logic host,
    input logic halve);
    logic [3:0] h;
    logic [2:0] l;
    logic [4:0] cm;
    logic [4:0] co;
    logic [3:0] dv;
    logic ok;
    h = c[6:3];
    l = c[2:0];
    cm = 5'h00;
    co = 5'h00;
    dv = 4'h0;
    ok = 1'b0;
    if (host) begin
      if (c == 7'h1a || c == 7'h1b) begin
        ok = 1'b1;
        cm = 5'h0a;
        co = (c == 7'h1a) ? 5'h0e : 5'h10;
        dv = 4'h5;
      end else if (h == 4'h4 && l < 3'h4) begin
        ok = 1'b1;
        cm = 5'h0c;
        co = 5'h0a + {1'b0, l, 1'b0};
        dv = 4'h6;
      end else if (h >= 4'h5 && h <= 4'hb && l <= 3'h4) begin
        ok = 1'b1;
        cm = host_comm[h - 4'h5];
        co = ((h <= 4'h9) ? 5'h05 : 5'h04) + {2'b00, l};
        dv = halve ? {host_div[h - 4'h5][2:0], 1'b0} : host_div[h - 4'h5];
      end
    end else if (c >= 7'h1c && c <= 7'h20) begin
      ok = 1'b1;
      cm = 5'h0c;
      co = 5'(7'h08 + 7'h02 * (c - 7'h1c));
    end else if (c >= 7'h2d && c <= 7'h38) begin
      ok = 1'b1;
      cm = (c <= 7'h32) ? 5'h04 : 5'h05;
      co = (c <= 7'h32) ? 5'(c - 7'h29) : 5'(c - 7'h2f);
    end
    return {ok, cm, co, dv};
  endfunction : expect_of

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic check_out(input logic [14:0] e);
    check("valid", {7'h00, valid}, {7'h00, e[14]});
    check("comm_mult", {3'h0, comm_mult}, {3'h0, e[13:9]});
    check("core_mult", {3'h0, core_mult}, {3'h0, e[8:4]});
    check("pci_div", {4'h0, pci_div}, {4'h0, e[3:0]});
    check("ready", {7'h00, ready}, 8'h01);
  endtask : check_out

  task automatic run_code(input logic [6:0] c, input logic host, input logic halve,
    input int stall);
    logic [14:0] e;
    e = expect_of(c, host, halve);
    @(posedge ref_clk);
    want_code <= c;
    want_host <= host;
    want_halve <= halve;
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    if (stall > 0) begin
      clk_en <= 1'b0;
      repeat (stall) @(posedge ref_clk);
      clk_en <= 1'b1;
    end
    @(posedge ref_clk);
    #1;
    check("ready_early", {7'h00, ready}, 8'h00);
    @(posedge ref_clk);
    #1;
    check_out(e);
    // straps keep toggling after release; ratios must not follow them
    repeat (3) @(posedge ref_clk);
    #1;
    check_out(e);
  endtask : run_code

  task automatic test_host;
    for (int hv = 0; hv < 2; hv++) begin
      for (int c = 0; c < 128; c++) begin
        run_code(7'(c), 1'b1, hv[0], 0);
      end
    end
    $display("test_host done");
  endtask : test_host

  task automatic test_general;
    for (int c = 0; c < 128; c++) begin
      run_code(7'(c), 1'b0, c[0], 0);
    end
    $display("test_general done");
  endtask : test_general

  task automatic test_stall;
    run_code(7'h4a, 1'b1, 1'b1, 3);
    run_code(7'h2d, 1'b0, 1'b0, 5);
    run_code(7'h24, 1'b0, 1'b1, 2);
    $display("test_stall done");
  endtask : test_stall

  task automatic end_sim;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // about 3500 cycles expected; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    test_host();
    test_general();
    test_stall();
    end_sim();
  end
endmodule : clock_mode_ratio_decoder_bench
`default_nettype wire
